// ### include/php_pkg.sv
// Shared constants and types of the PCM highway port
`default_nettype none

package php_pkg;

  // ----
  // Sizes
  // ----
  localparam int NUM_CH     = 4;
  localparam int CH_W       = 2;
  localparam int WORD_W     = 16;
  localparam int ADDR_W     = 4;
  localparam int REG_W      = 16;
  localparam int BIT_CNT_W  = 10;
  localparam int SLOT_W     = 7;
  localparam int IDX_W      = 4;
  localparam int OFS_W      = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_W     = 4;

  // ----
  // Register map (word index on the plain register port)
  // ----
  localparam logic [ADDR_W-1:0] ADDR_HWY_CFG  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_TX_SLOT0 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RX_SLOT0 = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h9;

  // highway_config_reg fields
  localparam int CFG_OFS_LSB  = 0;
  localparam int CFG_EDGE_BIT = 3;
  localparam int CFG_HALF_BIT = 4;
  localparam int CFG_LIN_BIT  = 5;

  // chan_tx_slot_reg / chan_rx_slot_reg fields
  localparam int SLOT_SEL_LSB = 0;
  localparam int SLOT_HWY_BIT = 7;
  localparam int SLOT_EN_BIT  = 8;

  // Status register fields
  localparam int STAT_SEEN_BIT  = 0;
  localparam int STAT_FRAME_BIT = 1;
  localparam int STAT_PEND_LSB  = 2;

  // Reset values
  localparam logic [REG_W-1:0] CFG_RST  = 16'h0000;
  localparam logic [REG_W-1:0] SLOT_RST = 16'h0000;

  // ----
  // Word positions and frame limits
  // ----
  localparam logic [IDX_W-1:0]     LAST_BIT_COMP = 4'h7;
  localparam logic [IDX_W-1:0]     LAST_BIT_LIN  = 4'hf;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX   = 10'h3ff;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO  = 10'h000;
  localparam logic [OFS_W-1:0]     OFS_ZERO      = 3'h0;
  localparam logic [OFS_W-1:0]     OFS_ONE       = 3'h1;

  // ----
  // Types
  // ----
  typedef struct packed {
    logic [CH_W-1:0]   chan;
    logic [WORD_W-1:0] data;
  } php_sample_t;

  typedef struct packed {
    logic [OFS_W-1:0] offset;
    logic             falling;
    logic             half_rate;
    logic             linear;
  } php_cfg_t;

endpackage : php_pkg

`default_nettype wire

// ### hw/php_sync.sv
// Two-flop synchroniser for the link pins
`default_nettype none

module php_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // php_sync

`default_nettype wire

// ### hw/php_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none

module php_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output var  logic             wr_ready_out,
  output var  logic [WIDTH-1:0] rd_data_out,
  output var  logic             rd_valid_out,
  input  wire logic             rd_ready_in
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0]   count_q;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count_q != (PTR_W+1)'(DEPTH));
  assign rd_valid_out = (count_q != '0);
  assign rd_data_out  = mem_q[rd_ptr_q];
  assign push         = wr_valid_in & wr_ready_out;
  assign pop          = rd_valid_out & rd_ready_in;

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (PTR_W+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (PTR_W+1)'(1);
      end
    end
  end

endmodule // php_fifo

`default_nettype wire

// ### hw/php_highway_port.sv
// PCM highway port: four channels on two transmit and two receive highways
`default_nettype none

module php_highway_port (
  input  wire logic                         core_clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic [php_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [php_pkg::REG_W-1:0]    reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output var  logic [php_pkg::REG_W-1:0]    reg_rdata_out,
  input  wire php_pkg::php_sample_t         tx_sample_in,
  input  wire logic                         tx_valid_in,
  output var  logic                         tx_ready_out,
  output var  php_pkg::php_sample_t         rx_sample_out,
  output var  logic                         rx_valid_out,
  input  wire logic                         bit_clock_in,
  input  wire logic                         frame_sync_in,
  input  wire logic                         rx_highway_one_in,
  input  wire logic                         rx_highway_two_in,
  output var  logic                         tx_highway_one_out,
  output var  logic                         tx_highway_one_oe_out,
  output var  logic                         tx_highway_two_out,
  output var  logic                         tx_highway_two_oe_out,
  output var  logic                         tx_active_one_n_out,
  output var  logic                         tx_active_one_n_oe_out,
  output var  logic                         tx_active_two_n_out,
  output var  logic                         tx_active_two_n_oe_out
);

  import php_pkg::*;

  // ----
  // Helpers
  // ----
  function automatic php_cfg_t cfg_decode(input logic [REG_W-1:0] r);
    php_cfg_t c;
    c.offset    = r[CFG_OFS_LSB +: OFS_W];
    c.falling   = r[CFG_EDGE_BIT];
    c.half_rate = r[CFG_HALF_BIT];
    c.linear    = r[CFG_LIN_BIT];
    return c;
  endfunction

  // Linear words take slot pair 2n and 2n+1
  function automatic logic slot_hit(input logic [REG_W-1:0]     sreg,
                                    input logic [BIT_CNT_W-1:0] cnt,
                                    input logic                 lin);
    logic [SLOT_W-1:0] sel;
    sel = sreg[SLOT_SEL_LSB +: SLOT_W];
    if (lin) begin
      return sreg[SLOT_EN_BIT] && (cnt[BIT_CNT_W-1:4] == sel[SLOT_W-2:0]) && !sel[SLOT_W-1];
    end
    return sreg[SLOT_EN_BIT] && (cnt[BIT_CNT_W-1:3] == sel);
  endfunction

  function automatic logic [IDX_W-1:0] word_idx(input logic [BIT_CNT_W-1:0] cnt,
                                                input logic                 lin);
    return lin ? cnt[IDX_W-1:0] : {1'b0, cnt[2:0]};
  endfunction

  function automatic logic [IDX_W-1:0] last_idx(input logic lin);
    return lin ? LAST_BIT_LIN : LAST_BIT_COMP;
  endfunction

  // ----
  // Pin synchronisation and edge detection
  // ----
  logic [SYNC_W-1:0] pins_s;
  logic              bclk_s;
  logic              fs_s;
  logic              rx_one_s;
  logic              rx_two_s;
  logic              bclk_prev_q;
  logic              rise;
  logic              fall;
  logic              launch_edge;
  logic              sample_edge;

  php_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .async_in    ({bit_clock_in, frame_sync_in, rx_highway_one_in, rx_highway_two_in}),
    .sync_out    (pins_s)
  );

  assign {bclk_s, fs_s, rx_one_s, rx_two_s} = pins_s;

  // ----
  // Registers
  // ----
  logic [REG_W-1:0]  cfg_q;
  logic [REG_W-1:0]  tx_slot_q [NUM_CH];
  logic [REG_W-1:0]  rx_slot_q [NUM_CH];
  php_cfg_t          cfg;
  logic              frame_seen_q;
  logic              in_frame_q;
  logic [NUM_CH-1:0] tx_pend_q;
  logic [REG_W-1:0]  rdata_d;

  assign cfg = cfg_decode(cfg_q);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= CFG_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        tx_slot_q[i] <= SLOT_RST;
        rx_slot_q[i] <= SLOT_RST;
      end
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_HWY_CFG) begin
        cfg_q <= reg_wdata_in;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr_in == ADDR_TX_SLOT0 + ADDR_W'(i)) begin
          tx_slot_q[i] <= reg_wdata_in;
        end
        if (reg_addr_in == ADDR_RX_SLOT0 + ADDR_W'(i)) begin
          rx_slot_q[i] <= reg_wdata_in;
        end
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    if (reg_addr_in == ADDR_HWY_CFG) begin
      rdata_d = cfg_q;
    end else if (reg_addr_in == ADDR_STATUS) begin
      rdata_d[STAT_SEEN_BIT]              = frame_seen_q;
      rdata_d[STAT_FRAME_BIT]             = in_frame_q;
      rdata_d[STAT_PEND_LSB +: NUM_CH]    = tx_pend_q;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (reg_addr_in == ADDR_TX_SLOT0 + ADDR_W'(i)) begin
        rdata_d = tx_slot_q[i];
      end
      if (reg_addr_in == ADDR_RX_SLOT0 + ADDR_W'(i)) begin
        rdata_d = rx_slot_q[i];
      end
    end
  end

  // Data stand for one cycle only; unmapped reads return zero
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_d : '0;
    end
  end

  // ----
  // Bit timing
  // ----
  logic                 fs_at_edge_q;
  logic                 phase_q;
  logic                 fs_rise;
  logic                 bit_tick;
  logic [OFS_W-1:0]     delay_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic                 active;
  logic                 out_upd_q;
  logic                 rx_pend_q;

  // Bit clock is only sampled, so it must stay well below core_clk / 4
  assign rise        = bclk_s & ~bclk_prev_q;
  assign fall        = ~bclk_s & bclk_prev_q;
  assign launch_edge = cfg.falling ? fall : rise;
  assign sample_edge = cfg.falling ? rise : fall;
  assign fs_rise     = launch_edge & fs_s & ~fs_at_edge_q;
  assign bit_tick    = launch_edge & (fs_rise | ~cfg.half_rate | ~phase_q);
  assign active      = in_frame_q & (delay_q == OFS_ZERO);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bclk_prev_q  <= 1'b0;
      fs_at_edge_q <= 1'b0;
      phase_q      <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_s;
      if (launch_edge) begin
        fs_at_edge_q <= fs_s;
        phase_q      <= fs_rise ? 1'b1 : ~phase_q;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      in_frame_q <= 1'b0;
      delay_q    <= OFS_ZERO;
      bit_cnt_q  <= BIT_CNT_ZERO;
    end else if (bit_tick) begin
      if (fs_rise) begin
        in_frame_q <= 1'b1;
        delay_q    <= cfg.offset;
        bit_cnt_q  <= BIT_CNT_ZERO;
      end else if (in_frame_q) begin
        if (delay_q != OFS_ZERO) begin
          delay_q <= delay_q - OFS_ONE;
        end else if (bit_cnt_q == BIT_CNT_MAX) begin
          in_frame_q <= 1'b0;
        end else begin
          bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      frame_seen_q <= 1'b0;
    end else if (bit_tick && fs_rise) begin
      frame_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      out_upd_q <= 1'b0;
      rx_pend_q <= 1'b0;
    end else begin
      out_upd_q <= bit_tick;
      if (bit_tick) begin
        rx_pend_q <= 1'b1;
      end else if (sample_edge) begin
        rx_pend_q <= 1'b0;
      end
    end
  end

  // ----
  // Transmit sample buffer
  // ----
  php_sample_t       head;
  logic              head_valid;
  logic              head_pop;
  logic [WORD_W-1:0] tx_next_q [NUM_CH];
  logic [WORD_W-1:0] tx_cur_q  [NUM_CH];

  // A channel takes one new word per frame; the buffer stalls meanwhile
  assign head_pop = head_valid & ~tx_pend_q[head.chan];

  php_fifo #(
    .WIDTH ($bits(php_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .arst_n_in    (arst_n_in),
    .wr_data_in   (tx_sample_in),
    .wr_valid_in  (tx_valid_in),
    .wr_ready_out (tx_ready_out),
    .rd_data_out  (head),
    .rd_valid_out (head_valid),
    .rd_ready_in  (head_pop)
  );

  // Word is repeated when software supplies none for a frame
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_pend_q <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        tx_next_q[i] <= '0;
        tx_cur_q[i]  <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (bit_tick && fs_rise && tx_pend_q[i]) begin
          tx_cur_q[i]  <= tx_next_q[i];
          tx_pend_q[i] <= 1'b0;
        end
      end
      if (head_pop) begin
        tx_next_q[head.chan] <= head.data;
        tx_pend_q[head.chan] <= 1'b1;
      end
    end
  end

  // ----
  // Transmit highways
  // ----
  logic             tx_found;
  logic             tx_hwy_two;
  logic             tx_bit;
  logic [IDX_W-1:0] idx;

  assign idx = word_idx(bit_cnt_q, cfg.linear);

  // Lowest channel wins if software overlaps slots
  always_comb begin
    tx_found   = 1'b0;
    tx_hwy_two = 1'b0;
    tx_bit     = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (active && slot_hit(tx_slot_q[i], bit_cnt_q, cfg.linear)) begin
        tx_found   = 1'b1;
        tx_hwy_two = tx_slot_q[i][SLOT_HWY_BIT];
        tx_bit     = tx_cur_q[i][last_idx(cfg.linear) - idx];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_highway_one_out    <= 1'b0;
      tx_highway_two_out    <= 1'b0;
      tx_highway_one_oe_out <= 1'b0;
      tx_highway_two_oe_out <= 1'b0;
    end else if (out_upd_q) begin
      tx_highway_one_out    <= tx_bit;
      tx_highway_two_out    <= tx_bit;
      tx_highway_one_oe_out <= frame_seen_q & tx_found & ~tx_hwy_two;
      tx_highway_two_oe_out <= frame_seen_q & tx_found & tx_hwy_two;
    end
  end

  // Open-drain indicators pull low exactly while their highway drives
  assign tx_active_one_n_out    = 1'b0;
  assign tx_active_two_n_out    = 1'b0;
  assign tx_active_one_n_oe_out = tx_highway_one_oe_out;
  assign tx_active_two_n_oe_out = tx_highway_two_oe_out;

  // ----
  // Receive highways
  // ----
  logic              rx_smp;
  logic [WORD_W-1:0] rx_shift_q [NUM_CH];
  logic              rx_done;
  php_sample_t       rx_word;

  // Sampled on the edge opposite to launch, inside the same bit period
  assign rx_smp = sample_edge & rx_pend_q & active;

  always_comb begin
    rx_done = 1'b0;
    rx_word = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (rx_smp && slot_hit(rx_slot_q[i], bit_cnt_q, cfg.linear) &&
          idx == last_idx(cfg.linear)) begin
        rx_done      = 1'b1;
        rx_word.chan = CH_W'(i);
        rx_word.data = {rx_shift_q[i][WORD_W-2:0],
                        rx_slot_q[i][SLOT_HWY_BIT] ? rx_two_s : rx_one_s};
        if (!cfg.linear) begin
          rx_word.data[WORD_W-1:8] = '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        rx_shift_q[i] <= '0;
      end
    end else if (rx_smp) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (slot_hit(rx_slot_q[i], bit_cnt_q, cfg.linear)) begin
          rx_shift_q[i] <= {rx_shift_q[i][WORD_W-2:0],
                            rx_slot_q[i][SLOT_HWY_BIT] ? rx_two_s : rx_one_s};
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_valid_out  <= 1'b0;
      rx_sample_out <= '0;
    end else begin
      rx_valid_out <= rx_done;
      if (rx_done) begin
        rx_sample_out <= rx_word;
      end
    end
  end

endmodule // php_highway_port

`default_nettype wire

// ### verif/php_highway_port_chk.sv
// Pin-level checker for the PCM highway port
`default_nettype none

module php_highway_port_chk (
  input wire logic                      core_clk_in,
  input wire logic                      arst_n_in,
  input wire logic                      reg_rd_in,
  input wire logic [php_pkg::REG_W-1:0] reg_rdata_out,
  input wire logic                      rx_valid_out,
  input wire logic                      bit_clock_in,
  input wire logic                      frame_sync_in,
  input wire logic                      tx_highway_one_out,
  input wire logic                      tx_highway_one_oe_out,
  input wire logic                      tx_highway_two_out,
  input wire logic                      tx_highway_two_oe_out,
  input wire logic                      tx_active_one_n_out,
  input wire logic                      tx_active_one_n_oe_out,
  input wire logic                      tx_active_two_n_out,
  input wire logic                      tx_active_two_n_oe_out
);
  import php_pkg::*;
  // ----
  // Helpers
  // ----
  logic       bc_prev_q;
  logic       seen_q;
  logic [3:0] bc_age_q;
  // Age saturates so a stalled bit clock cannot wrap back into the window
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bc_prev_q <= 1'b0;
      bc_age_q  <= 4'hf;
    end else begin
      bc_prev_q <= bit_clock_in;
      bc_age_q  <= (bit_clock_in != bc_prev_q) ? 4'h0 :
                   ((bc_age_q == 4'hf) ? 4'hf : bc_age_q + 4'h1);
    end
  end
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seen_q <= 1'b0;
    end else if (frame_sync_in) begin
      seen_q <= 1'b1;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_bclk_recent;
    bc_age_q < 4'h8;
  endsequence
  sequence s_no_read;
    !reg_rd_in;
  endsequence
  property p_quiet_before_sync;
    !seen_q |-> !tx_highway_one_oe_out && !tx_highway_two_oe_out;
  endproperty
  a_quiet_before_sync: assert property (p_quiet_before_sync)
    else $error("highway driven before first frame sync");
  property p_ind_one;
    tx_active_one_n_oe_out == tx_highway_one_oe_out;
  endproperty
  a_ind_one: assert property (p_ind_one)
    else $error("indicator one disagrees with highway one");
  property p_ind_two;
    tx_active_two_n_oe_out == tx_highway_two_oe_out;
  endproperty
  a_ind_two: assert property (p_ind_two)
    else $error("indicator two disagrees with highway two");
  property p_ind_level;
    !tx_active_one_n_out && !tx_active_two_n_out;
  endproperty
  a_ind_level: assert property (p_ind_level)
    else $error("indicator pulls high");
  property p_one_on_tick;
    $changed(tx_highway_one_out) || $changed(tx_highway_one_oe_out) |-> s_bclk_recent;
  endproperty
  a_one_on_tick: assert property (p_one_on_tick)
    else $error("highway one moved away from a bit clock edge");
  property p_two_on_tick;
    $changed(tx_highway_two_out) || $changed(tx_highway_two_oe_out) |-> s_bclk_recent;
  endproperty
  a_two_on_tick: assert property (p_two_on_tick)
    else $error("highway two moved away from a bit clock edge");
  property p_rx_on_tick;
    $rose(rx_valid_out) |-> s_bclk_recent;
  endproperty
  a_rx_on_tick: assert property (p_rx_on_tick)
    else $error("receive word completed away from a bit clock edge");
  property p_rdata_idle;
    s_no_read |=> reg_rdata_out == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
endmodule // php_highway_port_chk

bind php_highway_port php_highway_port_chk u_chk (
  .core_clk_in, .arst_n_in, .reg_rd_in, .reg_rdata_out, .rx_valid_out, .bit_clock_in,
  .frame_sync_in, .tx_highway_one_out, .tx_highway_one_oe_out, .tx_highway_two_out,
  .tx_highway_two_oe_out, .tx_active_one_n_out, .tx_active_one_n_oe_out,
  .tx_active_two_n_out, .tx_active_two_n_oe_out
);

`default_nettype wire

// ### verif/php_tdm_partner.sv
// Behavioural TDM backplane facing the PCM highway port
`default_nettype none

module php_tdm_partner #(
  parameter int FRAME_BITS = 64
) (
  input  wire logic                  fs_en_in,
  input  wire logic [FRAME_BITS-1:0] rx_one_frame_in,
  input  wire logic [FRAME_BITS-1:0] rx_two_frame_in,
  input  wire logic                  tx_one_in,
  input  wire logic                  tx_one_oe_in,
  input  wire logic                  tx_two_in,
  input  wire logic                  tx_two_oe_in,
  input  wire logic                  act_one_oe_in,
  output var  logic                  bit_clock_out,
  output var  logic                  frame_sync_out,
  output var  logic                  rx_one_out,
  output var  logic                  rx_two_out,
  output var  logic [FRAME_BITS-1:0] cap_one_out,
  output var  logic [FRAME_BITS-1:0] cap_two_out,
  output var  logic [FRAME_BITS-1:0] cap_act_out,
  output var  int                    frames_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Frame timing
  // ----
  // Short frame keeps the run brief; a real backplane spaces syncs at 8 kHz
  int                  cnt;
  logic [FRAME_BITS-1:0] sh_one;
  logic [FRAME_BITS-1:0] sh_two;
  logic [FRAME_BITS-1:0] sh_act;
  initial begin
    bit_clock_out = 1'b0;
    frame_sync_out = 1'b0;
    rx_one_out = 1'b0;
    rx_two_out = 1'b0;
    cnt = 0;
    frames_out = 0;
  end
  always #62.5 bit_clock_out = ~bit_clock_out;
  // Receive bits launched on the rising edge, a half period before sampling
  always @(posedge bit_clock_out) begin
    cnt = (cnt == FRAME_BITS - 1) ? 0 : cnt + 1;
    rx_one_out = rx_one_frame_in[FRAME_BITS-1-cnt];
    rx_two_out = rx_two_frame_in[FRAME_BITS-1-cnt];
  end
  // Sync changes on the falling edge so it is settled at the frame start edge
  always @(negedge bit_clock_out) begin
    frame_sync_out = fs_en_in && (cnt == FRAME_BITS - 1);
    sh_one = {sh_one[FRAME_BITS-2:0], tx_one_oe_in ? tx_one_in : 1'b1};
    sh_two = {sh_two[FRAME_BITS-2:0], tx_two_oe_in ? tx_two_in : 1'b1};
    sh_act = {sh_act[FRAME_BITS-2:0], !act_one_oe_in};
    if (cnt == FRAME_BITS - 1) begin
      cap_one_out = sh_one;
      cap_two_out = sh_two;
      cap_act_out = sh_act;
      frames_out++;
    end
  end
endmodule // php_tdm_partner

`default_nettype wire

// ### verif/test_php_highway_port.sv
// Self-checking bench for the PCM highway port
`default_nettype none

module test_php_highway_port;
  timeunit 1ns;
  timeprecision 1ps;
  import php_pkg::*;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [REG_W-1:0]  reg_wdata = '0, reg_rdata;
  php_sample_t       tx_sample = '0, rx_sample;
  logic              clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_valid = 1'b0;
  logic              fs_en = 1'b0, tx_ready, rx_valid;
  logic              bclk, fs, rx_one, rx_two, tx_one, tx_one_oe, tx_two, tx_two_oe, act_one_oe;
  logic [63:0]       rx_one_frame, rx_two_frame, cap_one, cap_two, cap_act;
  int                frames, n_mismatch = 0, n_tests = 0, k;
  php_sample_t       rx_last [NUM_CH];

  always #2 clk = ~clk;

  php_highway_port dut (
    .core_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .tx_sample_in(tx_sample), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .rx_sample_out(rx_sample), .rx_valid_out(rx_valid),
    .bit_clock_in(bclk), .frame_sync_in(fs), .rx_highway_one_in(rx_one),
    .rx_highway_two_in(rx_two), .tx_highway_one_out(tx_one),
    .tx_highway_one_oe_out(tx_one_oe), .tx_highway_two_out(tx_two),
    .tx_highway_two_oe_out(tx_two_oe), .tx_active_one_n_out(),
    .tx_active_one_n_oe_out(act_one_oe), .tx_active_two_n_out(),
    .tx_active_two_n_oe_out()
  );

  php_tdm_partner u_far (
    .fs_en_in(fs_en), .rx_one_frame_in(rx_one_frame), .rx_two_frame_in(rx_two_frame),
    .tx_one_in(tx_one), .tx_one_oe_in(tx_one_oe), .tx_two_in(tx_two),
    .tx_two_oe_in(tx_two_oe), .act_one_oe_in(act_one_oe), .bit_clock_out(bclk),
    .frame_sync_out(fs), .rx_one_out(rx_one), .rx_two_out(rx_two),
    .cap_one_out(cap_one), .cap_two_out(cap_two), .cap_act_out(cap_act),
    .frames_out(frames)
  );

  always @(posedge clk) begin
    if (rx_valid === 1'b1) rx_last[rx_sample.chan] <= rx_sample;
  end
  // ----
  // Tasks
  // ----
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic give_up();
    n_mismatch++;
    $display("MISMATCH wait limit exp done seen stuck");
    finish_test();
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(what, 64'(reg_rdata), 64'(exp));
  endtask
  // Valid stays up between pushes
  task automatic push(input logic [1:0] ch, input logic [15:0] d, input int bound);
    int i;
    tx_sample <= {ch, d};
    tx_valid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (tx_ready !== 1'b1 && i < bound);
    if (tx_ready !== 1'b1) give_up();
  endtask
  task automatic wait_frames(input int n);
    int tgt;
    int i;
    tgt = frames + n;
    for (i = 0; i < n * 2200 && frames < tgt; i++) @(posedge clk);
    if (frames < tgt) give_up();
  endtask
  function automatic logic [63:0] place(input logic [63:0] b, input int p, input logic [15:0] w);
    b[63-p -: 16] = w;
    return b;
  endfunction
  // ----
  // Sequence
  // ----
  initial begin
    rx_one_frame = 64'h3333_3333_5a33_3333;
    rx_two_frame = 64'hcccc_cc96_cccc_cccc;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd("cfg reset", ADDR_HWY_CFG, CFG_RST);
    rd("slot reset", ADDR_TX_SLOT0, SLOT_RST);
    rd("status idle", ADDR_STATUS, 16'h0000);
    wr(4'h1, 16'h0101);
    wr(4'h2, 16'h0182);
    wr(4'h3, 16'h0186);
    wr(4'h5, 16'h0183);
    wr(4'h6, 16'h0104);
    wr(4'hc, 16'hffff);
    rd("unmapped", 4'hc, 16'h0000);
    for (k = 0; k < 9; k++) push(2'h2, 16'h0077, 20);
    tx_valid <= 1'b0;
    repeat (3) @(posedge clk);
    check("fifo full", tx_ready, 1'b0);
    wait_frames(2);
    check("no sync idle", cap_one & cap_two, '1);
    fs_en <= 1'b1;
    push(2'h0, 16'h00a5, 3000);
    push(2'h1, 16'h003c, 3000);
    tx_valid <= 1'b0;
    wait_frames(12);
    check("hwy one", cap_one, 64'hffa5_ffff_ffff_ffff);
    check("ind one", cap_act, 64'hff00_ffff_ffff_ffff);
    check("hwy two", cap_two, 64'hffff_3cff_ffff_77ff);
    check("fifo drained", tx_ready, 1'b1);
    check("rx ch0", rx_last[0].data, 16'h0096);
    check("rx ch1", rx_last[1].data, 16'h005a);
    // Linear, offset three, falling launch; channel zero on highway two
    rx_one_frame = place(64'h3333_3333_3333_3333, 35, 16'h9c3e);
    wr(ADDR_HWY_CFG, 16'h002b);
    wr(4'h1, 16'h0181);
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h0000);
    wr(4'h5, 16'h0000);
    wr(4'h6, 16'h0102);
    rd("cfg", ADDR_HWY_CFG, 16'h002b);
    push(2'h0, 16'hc35a, 100);
    tx_valid <= 1'b0;
    wait_frames(4);
    check("linear two", cap_two, place('1, 19, 16'hc35a));
    check("linear one idle", cap_one, '1);
    check("linear rx", rx_last[1].data, 16'h9c3e);
    finish_test();
  end
endmodule // test_php_highway_port

`default_nettype wire
